/* verilog/tnr_pkg.sv */
/*
 * shared constants for the timing nco / resampler control words:
 * control word numbers, field positions, reset values and the host's
 * own avalon register map.
 * assumes both ends and the bench compile this package first.
 */
package tnr_pkg;
    // link, register and field widths
    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 32;
    localparam int FREQ_W  = 32;
    localparam int PHASE_W = 8;
    localparam int DLY_W   = 8;
    localparam int MODE_W  = 3;

    // control word numbers on the link
    localparam logic [ADDR_W-1:0] CW_NCO_CFG    = 5'h0b;
    localparam logic [ADDR_W-1:0] CW_FREQ_HOLD  = 5'h0c;
    localparam logic [ADDR_W-1:0] CW_PHASE_HOLD = 5'h0d;
    localparam logic [ADDR_W-1:0] CW_FREQ_STB   = 5'h0e;
    localparam logic [ADDR_W-1:0] CW_PHASE_STB  = 5'h0f;
    localparam logic [ADDR_W-1:0] CW_RESAMP     = 5'h10;

    // field positions
    localparam int SYNC_EN_BIT  = 5;
    localparam int LOAD_UPD_BIT = 0;
    localparam int DLY_LSB      = 4;
    localparam int DLY_MSB      = 11;
    localparam int BYPASS_BIT   = 3;
    localparam int MODE_LSB     = 0;
    localparam int MODE_MSB     = 2;

    // reset values: zero words, resampler section bypassed
    localparam logic [FREQ_W-1:0]  FREQ_RST   = 32'h0000_0000;
    localparam logic [PHASE_W-1:0] PHASE_RST  = 8'h00;
    localparam logic [DLY_W-1:0]   DLY_RST    = 8'h00;
    localparam logic [MODE_W-1:0]  MODE_RST   = 3'h0;
    localparam logic               BYPASS_RST = 1'b1;

    // pulse delay figures, in processing clocks
    localparam logic [DLY_W-1:0] DLY_ALIAS      = 8'h02;
    localparam logic [DLY_W-1:0] DLY_MAX        = 8'hff;
    localparam logic [DLY_W-1:0] DLY_HOST_MIN   = 8'h05;
    localparam logic [DLY_W-1:0] DLY_SERIAL_MIN = 8'h10;

    // host avalon register byte offsets
    localparam logic [4:0] HR_LINK_ADDR  = 5'h00;
    localparam logic [4:0] HR_LINK_WDATA = 5'h04;
    localparam logic [4:0] HR_COMMAND    = 5'h08;
    localparam logic [4:0] HR_STATUS     = 5'h0c;
    localparam logic [4:0] HR_RDATA      = 5'h10;
    localparam int CMD_WR_BIT   = 0;
    localparam int CMD_RD_BIT   = 1;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_REFUS_BIT = 1;

    // pulse scheduler and host states
    typedef enum logic [0:0] {
        TNR_P_IDLE  = 1'b0,
        TNR_P_SPACE = 1'b1
    } tnr_pulse_st_t;
    typedef enum logic [0:0] {
        TNR_H_IDLE   = 1'b0,
        TNR_H_RDWAIT = 1'b1
    } tnr_host_st_t;
endpackage

/* verilog/tnr_link_if.sv */
/*
 * control word link between host controller and device end.
 * assumes both ends run on the same processing clock; the bench
 * instantiates it and joins the two ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface tnr_link_if;
    logic                      wr;
    logic                      rd;
    logic [tnr_pkg::ADDR_W-1:0] addr;
    logic [tnr_pkg::DATA_W-1:0] wdata;
    logic [tnr_pkg::DATA_W-1:0] rdata;
    logic                      rvalid;

    // device end receives orders, returns read data
    modport dev (input wr, rd, addr, wdata, output rdata, rvalid);
    // host end issues orders
    modport host (output wr, rd, addr, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

/* verilog/tnr_device.sv */
/*
 * device end: timing nco and resampler control word registers.
 * assumes one-cycle link pulses on the processing clock; the sync
 * pin is asynchronous.
 */
// Chosen here: the placing of the registers and the Avalon-MM register port.
//
// Contract
// - all control words act on processing clock
// - hold 32-bit centre frequency word, msb 31
// - frequency strobe write copies hold to active
// - enabled sync loads frequency and phase actives
// - hold 8-bit phase offset, msb 7
// - phase strobe write copies hold to active
// - pulse delay field spaces extra outputs
// - delay value two means 255 clocks
// - x2 gives one extra, x4 three
// - host programs delay as clock/rate minus one
// - host programs pulse delay at least five; tnr_host also passes delay two, the 255 alias
// - delay under sixteen may preempt serial word
// - bypass bit skips whole resampling section
// - mode bits enable hb2, hb1, resampler
// - load-on-update also zeroes phase accumulator
`timescale 1ns/1ns
`default_nettype none
module tnr_device (
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   nrst_in,
    // control word link
    tnr_link_if.dev                     link,
    // external timing sync pin
    input  wire logic                   timing_sync_input_in,
    // resampler input sample timing
    input  wire logic                   sample_strobe_in,
    // active nco words
    output logic [tnr_pkg::FREQ_W-1:0]  active_freq_out,
    output logic [tnr_pkg::PHASE_W-1:0] active_phase_out,
    output logic                        phase_acc_zero_out,
    // resampler configuration
    output logic                        section_bypass_out,
    output logic                        resampler_en_out,
    output logic                        first_interp_halfband_en_out,
    output logic                        second_interp_halfband_en_out,
    output logic                        mode_valid_out,
    output logic [tnr_pkg::DLY_W-1:0]   pulse_spacing_out,
    output logic                        delay_invalid_out,
    output logic                        serial_preempt_risk_out,
    // interpolated output pulses
    output logic                        out_pulse_out
);
    import tnr_pkg::*;

    logic [FREQ_W-1:0]  freq_hold;
    logic [PHASE_W-1:0] phase_hold;
    logic               sync_en;
    logic               load_on_upd;
    logic [DLY_W-1:0]   pulse_dly;
    logic               bypass;
    logic [MODE_W-1:0]  mode;
    logic [2:0]         sync_ff;
    logic               sync_lvl;
    logic               sync_pulse;
    logic               freq_stb;
    logic               phase_stb;
    logic               sync_load;
    tnr_pulse_st_t      pulse_st;
    logic [DLY_W-1:0]   space_cnt;
    logic [1:0]         extras_left;

    // write decode for one control word
    function automatic logic cw_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] cw);
        return a == cw;
    endfunction

    // valid filter mode codes
    function automatic logic mode_ok(input logic [MODE_W-1:0] m);
        return m inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    endfunction

    // programmed delay to real spacing
    function automatic logic [DLY_W-1:0] eff_delay(
        input logic [DLY_W-1:0] d);
        return (d == DLY_ALIAS) ? DLY_MAX : d;
    endfunction

    // extra outputs per input sample
    function automatic logic [1:0] extra_count(input logic byp,
                                               input logic [MODE_W-1:0] m);
        if (byp || !mode_ok(m)) begin
            return 2'h0;
        end
        return m[2] ? 2'h3 : {1'b0, m[1]};
    endfunction

    // strobe writes carry no data; any value fires
    assign freq_stb  = link.wr && cw_hit(link.addr, CW_FREQ_STB);
    assign phase_stb = link.wr && cw_hit(link.addr, CW_PHASE_STB);
    assign sync_load = sync_pulse && sync_en;

    // sync pin: three flops, level taken when last two agree
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_ff    <= 3'h0;
            sync_lvl   <= 1'b0;
            sync_pulse <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], timing_sync_input_in};
            if (sync_ff[1] == sync_ff[2]) begin
                sync_lvl <= sync_ff[2];
            end
            // rising edge of the settled level, one cycle
            sync_pulse <= sync_ff[1] && sync_ff[2] && !sync_lvl;
        end
    end

    // holding registers; reserved bits simply not stored
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            freq_hold   <= FREQ_RST;
            phase_hold  <= PHASE_RST;
            sync_en     <= 1'b0;
            load_on_upd <= 1'b0;
        end else if (link.wr) begin
            if (cw_hit(link.addr, CW_FREQ_HOLD)) begin
                freq_hold <= link.wdata[FREQ_W-1:0];
            end
            if (cw_hit(link.addr, CW_PHASE_HOLD)) begin
                phase_hold <= link.wdata[PHASE_W-1:0];
            end
            if (cw_hit(link.addr, CW_NCO_CFG)) begin
                sync_en     <= link.wdata[SYNC_EN_BIT];
                load_on_upd <= link.wdata[LOAD_UPD_BIT];
            end
        end
    end

    // resampler control word
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pulse_dly <= DLY_RST;
            bypass    <= BYPASS_RST;
            mode      <= MODE_RST;
        end else if (link.wr && cw_hit(link.addr, CW_RESAMP)) begin
            pulse_dly <= link.wdata[DLY_MSB:DLY_LSB];
            bypass    <= link.wdata[BYPASS_BIT];
            mode      <= link.wdata[MODE_MSB:MODE_LSB];
        end
    end

    // active nco words; sync load sees the hold value before this edge
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_freq_out    <= FREQ_RST;
            active_phase_out   <= PHASE_RST;
            phase_acc_zero_out <= 1'b0;
        end else begin
            if (freq_stb || sync_load) begin
                active_freq_out <= freq_hold;
            end
            if (phase_stb || sync_load) begin
                active_phase_out <= phase_hold;
            end
            // phase strobe alone is no frequency update
            phase_acc_zero_out <= load_on_upd && (freq_stb || sync_load);
        end
    end

    // decoded configuration, one cycle behind the word
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            section_bypass_out            <= BYPASS_RST;
            resampler_en_out              <= 1'b0;
            first_interp_halfband_en_out  <= 1'b0;
            second_interp_halfband_en_out <= 1'b0;
            mode_valid_out                <= 1'b0;
            pulse_spacing_out             <= DLY_RST;
            delay_invalid_out             <= 1'b0;
            serial_preempt_risk_out       <= 1'b0;
        end else begin
            section_bypass_out <= bypass;
            // invalid codes enable nothing rather than half a chain
            {second_interp_halfband_en_out, first_interp_halfband_en_out,
             resampler_en_out} <= (!bypass && mode_ok(mode)) ?
                                  mode : 3'h0;
            mode_valid_out    <= bypass || mode_ok(mode);
            pulse_spacing_out <= eff_delay(pulse_dly);
            delay_invalid_out <= pulse_dly < DLY_ALIAS;
            serial_preempt_risk_out <= eff_delay(pulse_dly) <
                                       DLY_SERIAL_MIN;
        end
    end

    // output pulses: first on the sample, extras each spacing clocks
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pulse_st      <= TNR_P_IDLE;
            space_cnt     <= 8'h00;
            extras_left   <= 2'h0;
            out_pulse_out <= 1'b0;
        end else begin
            out_pulse_out <= 1'b0;
            if (sample_strobe_in && !bypass && mode_ok(mode)) begin
                // a new sample restarts the burst; invalid delay: no extras
                out_pulse_out <= 1'b1;
                space_cnt     <= 8'h01;
                extras_left   <= extra_count(bypass, mode);
                if (extra_count(bypass, mode) != 2'h0 &&
                    pulse_dly >= DLY_ALIAS) begin
                    pulse_st <= TNR_P_SPACE;
                end else begin
                    pulse_st <= TNR_P_IDLE;
                end
            end else begin
                case (pulse_st)
                    TNR_P_IDLE: begin
                        space_cnt <= 8'h00;
                    end
                    TNR_P_SPACE: begin
                        if (space_cnt == eff_delay(pulse_dly)) begin
                            out_pulse_out <= 1'b1;
                            space_cnt     <= 8'h01;
                            extras_left   <= extras_left - 2'h1;
                            if (extras_left == 2'h1) begin
                                pulse_st <= TNR_P_IDLE;
                            end
                        end else begin
                            space_cnt <= space_cnt + 8'h01;
                        end
                    end
                    default: begin
                        pulse_st <= TNR_P_IDLE;
                    end
                endcase
            end
        end
    end

    // read back; strobes and unmapped words read zero
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            link.rvalid <= 1'b0;
            link.rdata  <= 32'h0000_0000;
        end else begin
            link.rvalid <= link.rd;
            link.rdata  <= 32'h0000_0000;
            if (link.rd) begin
                case (link.addr)
                    CW_NCO_CFG: begin
                        link.rdata[SYNC_EN_BIT]  <= sync_en;
                        link.rdata[LOAD_UPD_BIT] <= load_on_upd;
                    end
                    CW_FREQ_HOLD: begin
                        link.rdata <= freq_hold;
                    end
                    CW_PHASE_HOLD: begin
                        link.rdata[PHASE_W-1:0] <= phase_hold;
                    end
                    CW_RESAMP: begin
                        link.rdata[DLY_MSB:DLY_LSB]   <= pulse_dly;
                        link.rdata[BYPASS_BIT]        <= bypass;
                        link.rdata[MODE_MSB:MODE_LSB] <= mode;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/tnr_host.sv */
/*
 * host end: avalon-mm slave with waitrequest that turns software
 * orders into control word writes and reads on the link, and refuses
 * resampler words that the device must not be given.
 * assumes the device end answers a read with rvalid a cycle later.
 */
`timescale 1ns/1ns
`default_nettype none
module tnr_host (
    // clock and reset
    input  wire logic                        core_clk_in,
    input  wire logic                        nrst_in,
    // avalon-mm slave
    input  wire logic [4:0]                  avs_address_in,
    input  wire logic                        avs_read_in,
    input  wire logic                        avs_write_in,
    input  wire logic [tnr_pkg::DATA_W-1:0]  avs_writedata_in,
    output logic [tnr_pkg::DATA_W-1:0]       avs_readdata_out,
    output logic                             avs_waitrequest_out,
    // control word link
    tnr_link_if.host                         link
);
    import tnr_pkg::*;

    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_wdata;
    logic [DATA_W-1:0] rd_data;
    logic              refused;
    logic              busy;
    logic              rd_ack;
    logic              cmd_wr;
    logic              go_wr;
    logic              go_rd;
    logic              bad_word;
    tnr_host_st_t      state;

    // resampler word the device may be given
    function automatic logic resamp_ok(input logic [DATA_W-1:0] w);
        logic [MODE_W-1:0] m;
        logic [DLY_W-1:0]  d;
        m = w[MODE_MSB:MODE_LSB];
        d = w[DLY_MSB:DLY_LSB];
        // delay two aliases to 255, so it passes
        return w[BYPASS_BIT] ||
               (m inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7} &&
                (d == DLY_ALIAS || d >= DLY_HOST_MIN));
    endfunction

    assign busy     = (state == TNR_H_RDWAIT) || link.wr || link.rd;
    assign cmd_wr   = avs_write_in && avs_address_in == HR_COMMAND;
    assign go_wr    = cmd_wr && !busy && avs_writedata_in[CMD_WR_BIT];
    assign go_rd    = cmd_wr && !busy && !avs_writedata_in[CMD_WR_BIT] &&
                      avs_writedata_in[CMD_RD_BIT];
    assign bad_word = cmd_addr == CW_RESAMP && !resamp_ok(cmd_wdata);

    // command waits while a transfer runs; reads take one wait cycle
    assign avs_waitrequest_out = (cmd_wr && busy) ||
                                 (avs_read_in && !rd_ack);

    // order registers, written only while no transfer is busy; writes taken meanwhile are dropped
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_addr  <= 5'h00;
            cmd_wdata <= 32'h0000_0000;
        end else if (avs_write_in && !busy) begin
            if (avs_address_in == HR_LINK_ADDR) begin
                cmd_addr <= avs_writedata_in[ADDR_W-1:0];
            end
            if (avs_address_in == HR_LINK_WDATA) begin
                cmd_wdata <= avs_writedata_in;
            end
        end
    end

    // refusal flag: set wins over software clear
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            refused <= 1'b0;
        end else if (go_wr && bad_word) begin
            refused <= 1'b1;
        end else if (avs_write_in && avs_address_in == HR_STATUS &&
                     avs_writedata_in[ST_REFUS_BIT]) begin
            refused <= 1'b0;
        end
    end

    // link sequencer: one-cycle pulses, read waits for rvalid
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state      <= TNR_H_IDLE;
            link.wr    <= 1'b0;
            link.rd    <= 1'b0;
            link.addr  <= 5'h00;
            link.wdata <= 32'h0000_0000;
            rd_data    <= 32'h0000_0000;
        end else begin
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            case (state)
                TNR_H_IDLE: begin
                    if (go_wr && !bad_word) begin
                        link.wr    <= 1'b1;
                        link.addr  <= cmd_addr;
                        link.wdata <= cmd_wdata;
                    end else if (go_rd) begin
                        link.rd   <= 1'b1;
                        link.addr <= cmd_addr;
                        state     <= TNR_H_RDWAIT;
                    end
                end
                TNR_H_RDWAIT: begin
                    if (link.rvalid) begin
                        rd_data <= link.rdata;
                        state   <= TNR_H_IDLE;
                    end
                end
                default: begin
                    state <= TNR_H_IDLE;
                end
            endcase
        end
    end

    // avalon read data, registered during the wait cycle
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_ack           <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            rd_ack <= avs_read_in && !rd_ack;
            if (avs_read_in && !rd_ack) begin
                case (avs_address_in)
                    HR_LINK_ADDR:  avs_readdata_out <= {27'h0, cmd_addr};
                    HR_LINK_WDATA: avs_readdata_out <= cmd_wdata;
                    HR_STATUS:     avs_readdata_out <= {30'h0, refused, busy};
                    HR_RDATA:      avs_readdata_out <= rd_data;
                    default:       avs_readdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tnr_sva.sv */
/* checker for the control word link and the device end's outputs.
   assumes the bench instantiates it beside the link, one clock. */
`timescale 1ns/1ns
`default_nettype none
module tnr_sva (
    // clock and reset
    input wire logic                        core_clk_in,
    input wire logic                        nrst_in,
    // link
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [tnr_pkg::ADDR_W-1:0]  addr,
    input wire logic [tnr_pkg::DATA_W-1:0]  wdata,
    input wire logic [tnr_pkg::DATA_W-1:0]  rdata,
    input wire logic                        rvalid,
    // device pins
    input wire logic                        timing_sync_input_in,
    input wire logic [tnr_pkg::FREQ_W-1:0]  active_freq_out,
    input wire logic [tnr_pkg::PHASE_W-1:0] active_phase_out,
    input wire logic                        phase_acc_zero_out,
    input wire logic                        section_bypass_out,
    input wire logic                        resampler_en_out,
    input wire logic                        first_interp_halfband_en_out,
    input wire logic                        second_interp_halfband_en_out,
    input wire logic [tnr_pkg::DLY_W-1:0]   pulse_spacing_out,
    input wire logic                        delay_invalid_out
);
    import tnr_pkg::*;
    logic [3:0] sync_age;
    // cycles since the sync pin was high; loads may lag it a few clocks
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in)
            sync_age <= 4'hf;
        else if (timing_sync_input_in)
            sync_age <= 4'h0;
        else if (sync_age != 4'hf)
            sync_age <= sync_age + 4'h1;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // link answers and device loads
    chk_rd_answer: assert property (rd |=> rvalid)
        else $error("read not answered next cycle");
    chk_rdata_idle: assert property (!rvalid |-> rdata == '0)
        else $error("read data outside answer");
    chk_freq_load: assert property ($changed(active_freq_out) |->
        $past(wr && addr == CW_FREQ_STB) || sync_age < 4'h8)
        else $error("active frequency moved without cause");
    chk_phase_load: assert property ($changed(active_phase_out) |->
        $past(wr && addr == CW_PHASE_STB) || sync_age < 4'h8)
        else $error("active phase moved without cause");
    chk_zero_cause: assert property (phase_acc_zero_out |->
        $past(wr && addr == CW_FREQ_STB) || sync_age < 4'h8)
        else $error("accumulator zeroed without load");
    chk_bypass_gate: assert property (section_bypass_out |->
        !(resampler_en_out || first_interp_halfband_en_out
          || second_interp_halfband_en_out))
        else $error("filter enabled while bypassed");
    chk_delay_invalid: assert property (wr && addr == CW_RESAMP |->
        ##2 delay_invalid_out == ($past(wdata[DLY_MSB:DLY_LSB], 2) < 8'h02))
        else $error("invalid delay flag wrong");
    chk_delay_alias: assert property (wr && addr == CW_RESAMP
        && wdata[DLY_MSB:DLY_LSB] == DLY_ALIAS |-> ##2 pulse_spacing_out == DLY_MAX)
        else $error("delay two not read as maximum");
    cov_read: cover property (rd ##1 rvalid);
    cov_zero: cover property (phase_acc_zero_out);
    cov_active: cover property (!section_bypass_out && resampler_en_out);
endmodule
`default_nettype wire

/* tb/timing_nco_resampler_ctrl_bench.sv */
/* bench for host and device ends joined by the link.
   assumes the package, link and both ends are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module timing_nco_resampler_ctrl_bench;
    import tnr_pkg::*;
    logic        core_clk_in = 1'b0, nrst_in = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, rck = 1'b0, wq, ok;
    logic        sync = 1'b0, smp = 1'b0, byp, ren, h1, h2, dinv, risk, pls, z, mv;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = '0, q, f, p, rdat, afreq;
    logic [7:0]  aph, spc, md[4] = '{1, 3, 7, 3}, dl[4] = '{5, 6, 5, 2};
    int          n_fail = 0, num_checks = 0, np = 0, ex[4] = '{1, 2, 4, 2};
    logic [31:0] exq[$];
    tnr_link_if link ();
    tnr_device tnr_device_i (.core_clk_in, .nrst_in, .link(link.dev),
        .timing_sync_input_in(sync), .sample_strobe_in(smp),
        .active_freq_out(afreq), .active_phase_out(aph),
        .phase_acc_zero_out(z), .section_bypass_out(byp),
        .resampler_en_out(ren), .first_interp_halfband_en_out(h1),
        .second_interp_halfband_en_out(h2), .mode_valid_out(mv),
        .pulse_spacing_out(spc), .delay_invalid_out(dinv),
        .serial_preempt_risk_out(risk), .out_pulse_out(pls));
    tnr_host tnr_host_i (.core_clk_in, .nrst_in, .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .link(link.host));
    tnr_sva chk_i (.core_clk_in, .nrst_in, .wr(link.wr), .rd(link.rd),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .rvalid(link.rvalid), .timing_sync_input_in(sync),
        .active_freq_out(afreq), .active_phase_out(aph),
        .phase_acc_zero_out(z),
        .section_bypass_out(byp), .resampler_en_out(ren),
        .first_interp_halfband_en_out(h1),
        .second_interp_halfband_en_out(h2), .pulse_spacing_out(spc),
        .delay_invalid_out(dinv));
    initial forever #5 core_clk_in = ~core_clk_in;
    // checked reads take the oldest note off the queue
    always @(posedge core_clk_in) begin
        if (rd && rck && wq === 1'b0)
            ck(rdat, exq.pop_front());
    end
    // interpolated outputs seen
    always @(posedge core_clk_in) begin
        if (pls === 1'b1)
            np++;
    end
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    // one avalon cycle; for a checked read d is the expected data
    task automatic av(input logic w, input logic c, input logic [4:0] a,
                      input logic [31:0] d);
        if (c)
            exq.push_back(d);
        adr <= a;
        wr <= w;
        rd <= !w;
        rck <= c;
        wd <= d;
        do @(posedge core_clk_in); while (wq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        rck <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic go(input logic [4:0] cw, input logic [31:0] d,
                      input logic [31:0] cmd);
        av(1, 0, HR_LINK_ADDR, {27'h0, cw});
        av(1, 0, HR_LINK_WDATA, d);
        av(1, 0, HR_COMMAND, cmd);
        do av(0, 0, HR_STATUS, '0); while (q[ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic lr(input logic [4:0] cw, input logic [31:0] e);
        go(cw, '0, 32'h2);
        av(0, 1, HR_RDATA, e);
    endtask
    task automatic sy;
        sync <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        sync <= 1'b0;
        repeat (8) @(posedge core_clk_in);
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #500_000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        f = $urandom(51553);
        repeat (4) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(posedge core_clk_in);
        ck(byp, 1);
        lr(CW_RESAMP, 32'h8);
        av(0, 1, 5'h14, '0);
        lr(5'h1f, '0);
        go(CW_NCO_CFG, '1, 32'h1);
        lr(CW_NCO_CFG, 32'h21);
        f = $urandom;
        go(CW_FREQ_HOLD, f, 32'h1);
        lr(CW_FREQ_HOLD, f);
        ck(afreq, 0);
        go(CW_FREQ_STB, $urandom, 32'h1);
        ck(afreq, f);
        p = $urandom;
        go(CW_PHASE_HOLD, p, 32'h1);
        lr(CW_PHASE_HOLD, {24'h0, p[7:0]});
        go(CW_PHASE_STB, '0, 32'h1);
        ck(aph, p[7:0]);
        f = $urandom;
        p = $urandom;
        go(CW_FREQ_HOLD, f, 32'h1);
        go(CW_PHASE_HOLD, p, 32'h1);
        sy();
        ck(afreq, f);
        ck(aph, p[7:0]);
        go(CW_NCO_CFG, 32'h1, 32'h1);
        go(CW_FREQ_HOLD, ~f, 32'h1);
        sy();
        ck(afreq, f);
        // every mode code; refused codes must set the refusal flag
        for (int m = 0; m < 8; m++) begin
            ok = m inside {1, 2, 3, 6, 7};
            go(CW_RESAMP, {20'h0, 8'h10, 1'b0, m[2:0]}, 32'h1);
            if (ok)
                ck({byp, risk, h2, h1, ren, mv}, {2'b00, m[2:0], 1'b1});
            av(0, 1, HR_STATUS, {30'h0, !ok, 1'b0});
            av(1, 0, HR_STATUS, 32'h2);
        end
        // pulse spacing and extra output counts
        for (int i = 0; i < 4; i++) begin
            go(CW_RESAMP, {20'h0, dl[i], 1'b0, md[i][2:0]}, 32'h1);
            ck(spc, i == 3 ? 8'hff : dl[i]);
            np = 0;
            smp <= 1'b1;
            @(posedge core_clk_in);
            smp <= 1'b0;
            repeat (i == 3 ? 300 : 30) @(posedge core_clk_in);
            ck(np, ex[i]);
        end
        go(CW_RESAMP, 32'hfff0_000f, 32'h1);
        ck({byp, ren, dinv}, 3'b101);
        lr(CW_RESAMP, 32'hf);
        report_and_stop();
    end
endmodule
`default_nettype wire
